// >>> hdl/bia_pkg.sv
/*
  package for the board interrupt aggregator: port addresses, field
  positions, reset values and cpu interrupt line numbers.
  assumes nothing of its surroundings.
*/
package bia_pkg;
  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  localparam int BIA_ADDR_W = 3;
  localparam logic [2:0] BIA_CS_MATCH = 3'h1;
  localparam logic [2:0] BIA_LOW_ONE = 3'h4;
  localparam logic [2:0] BIA_LOW_TWO = 3'h5;
  localparam logic [2:0] BIA_LOW_THREE = 3'h6;
  localparam logic [11:0] BIA_OFS_ONE = 12'h804;
  localparam logic [11:0] BIA_OFS_TWO = 12'h805;
  localparam logic [11:0] BIA_OFS_THREE = 12'h806;
  // ----------------------------------------------------------------
  // sources and masks
  // ----------------------------------------------------------------
  localparam int BIA_NSRC = 17;
  localparam logic [16:0] BIA_MASK_RST = 17'h1FFFF;
  localparam logic [7:0] BIA_ZERO8 = 8'h00;
  localparam int BIA_BRIDGE_BIT = 4;
  // ----------------------------------------------------------------
  // cpu interrupt lines and priority levels
  // ----------------------------------------------------------------
  localparam int BIA_NIRQ = 4;
  localparam int BIA_IRQ_CORR = 0;
  localparam int BIA_IRQ_IO = 1;
  localparam int BIA_IRQ_CAL = 2;
  localparam int BIA_IRQ_RSVD = 3;
  localparam int BIA_PRIORITY_LEVEL_CORR = 20;
  localparam int BIA_PRIORITY_LEVEL_IO = 21;
  localparam int BIA_PRIORITY_LEVEL_CAL = 22;
  localparam int BIA_PRIORITY_LEVEL_MCHK = 31;
endpackage

// >>> hdl/bia_mask_reg.sv
/*
  one write-only mask register of 1 to 8 bits (8 by default).
  assumes a one-cycle write strobe synchronous to clk.
*/
`timescale 1ns/100ps
module bia_mask_reg #(
  parameter int WIDTH = 8,
  parameter logic [7:0] RST_VAL = 8'hFF
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] mask
);
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("mask width out of range");
  end

  logic [WIDTH-1:0] mask_r;
  logic [WIDTH-1:0] mask_nxt;

  assign mask_nxt = wr_en ? wr_data : mask_r;
  assign mask = mask_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mask_r <= RST_VAL[WIDTH-1:0];
    else
      mask_r <= mask_nxt;
  end
endmodule

// >>> hdl/bia_port_decode.sv
/*
  port decoder: turns the low address bits and chip-select bits into
  one-hot port selects.
  assumes address and strobes stable and synchronous to clk.
*/
`timescale 1ns/100ps
module bia_port_decode
  import bia_pkg::*;
(
  input wire logic [2:0] system_addr_low,
  input wire logic [2:0] cs_addr,
  output logic sel_one,
  output logic sel_two,
  output logic sel_three
);
  wire cs_hit;
  assign cs_hit = (cs_addr == BIA_CS_MATCH);
  assign sel_one = cs_hit && (system_addr_low == BIA_LOW_ONE);
  assign sel_two = cs_hit && (system_addr_low == BIA_LOW_TWO);
  assign sel_three = cs_hit && (system_addr_low == BIA_LOW_THREE);
endmodule

// >>> hdl/bia_board_interrupt_aggregator.sv
/*
  board interrupt aggregator: gathers slot, bridge, calendar-clock and
  system-bridge interrupts onto cpu interrupt lines 0 to 2 and the
  machine-check line; 8-bit i/o slave with raw status reads and
  write-only masks.
  assumes i/o strobes and address synchronous to clk, one clock domain.
*/
`timescale 1ns/100ps
module bia_board_interrupt_aggregator
  import bia_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] system_addr_low,
  input wire logic [2:0] cs_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_data_oe,
  input wire logic [3:0] slot_a_line,
  input wire logic [3:0] slot_b_line,
  input wire logic [3:0] slot_c_line,
  input wire logic [3:0] slot_d_line,
  input wire logic bridge_irq,
  input wire logic calendar_clock_event,
  input wire logic sysbr_corr_irq,
  input wire logic sysbr_err_irq,
  input wire logic bridge_missing_mem,
  input wire logic bridge_error,
  input wire logic [3:0] clock_ratio_jumpers,
  output logic [3:0] cpu_irq,
  output logic pwr_fail_irq,
  output logic sys_mch_chk_irq,
  output logic mch_hlt_irq
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (BIA_NSRC != 17)
  begin : g_bad_nsrc
    $error("status source count must be seventeen");
  end
  if (BIA_NIRQ != 4 || BIA_IRQ_RSVD >= BIA_NIRQ)
  begin : g_bad_nirq
    $error("cpu interrupt line numbering out of range");
  end
  if (BIA_MASK_RST != 17'h1FFFF)
  begin : g_bad_mask_rst
    $error("masks must reset to all ones");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic sel_one;
  logic sel_two;
  logic sel_three;
  wire any_sel;

  bia_port_decode u_dec (
    .system_addr_low(system_addr_low),
    .cs_addr(cs_addr),
    .sel_one(sel_one),
    .sel_two(sel_two),
    .sel_three(sel_three)
  );
  assign any_sel = sel_one || sel_two || sel_three;

  // ----------------------------------------------------------------
  // raw status bits
  // ----------------------------------------------------------------
  wire [7:0] stat_one;
  wire [7:0] stat_two;
  wire [7:0] stat_three;
  wire [16:0] stat_all;
  assign stat_one = {slot_b_line[2:0], bridge_irq, slot_a_line};
  assign stat_two = {slot_d_line[2:0], slot_c_line, slot_b_line[3]};
  assign stat_three = {7'h00, slot_d_line[3]};
  assign stat_all = {stat_three[0], stat_two, stat_one};

  // ----------------------------------------------------------------
  // masks
  // ----------------------------------------------------------------
  logic [7:0] mask_one;
  logic [7:0] mask_two;
  logic [0:0] mask_three;
  wire [16:0] mask_all;

  bia_mask_reg #(.WIDTH(8), .RST_VAL(BIA_MASK_RST[7:0])) u_m1 (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(io_wr && sel_one),
    .wr_data(wr_data),
    .mask(mask_one)
  );
  bia_mask_reg #(.WIDTH(8), .RST_VAL(BIA_MASK_RST[15:8])) u_m2 (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(io_wr && sel_two),
    .wr_data(wr_data),
    .mask(mask_two)
  );
  bia_mask_reg #(.WIDTH(1), .RST_VAL({7'h00, BIA_MASK_RST[16]})) u_m3 (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(io_wr && sel_three),
    .wr_data(wr_data[0]),
    .mask(mask_three)
  );
  assign mask_all = {mask_three, mask_two, mask_one};

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic rd_oe_r;
  wire [7:0] rd_mux;

  // status only, never mask contents
  assign rd_mux = sel_one ? stat_one :
                  sel_two ? stat_two :
                  sel_three ? stat_three : BIA_ZERO8;
  assign rd_data_nxt = (io_rd && any_sel) ? rd_mux : BIA_ZERO8;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_r <= BIA_ZERO8;
      rd_oe_r <= 1'b0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
      rd_oe_r <= io_rd && any_sel;
    end
  end
  assign rd_data = rd_data_r;
  assign rd_data_oe = rd_oe_r;

  // ----------------------------------------------------------------
  // cpu interrupt generation
  // ----------------------------------------------------------------
  logic [3:0] irq_r;
  logic [3:0] irq_nxt;
  logic mchk_r;
  wire bridge_fault;
  wire io_pending;

  assign bridge_fault = bridge_missing_mem || bridge_error;
  assign io_pending = |(stat_all & ~mask_all);
  assign irq_nxt[BIA_IRQ_CORR] = sysbr_corr_irq;
  assign irq_nxt[BIA_IRQ_IO] = io_pending;
  assign irq_nxt[BIA_IRQ_CAL] = calendar_clock_event;
  assign irq_nxt[BIA_IRQ_RSVD] = 1'b0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_r <= 4'h0;
      mchk_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
      mchk_r <= bridge_fault || sysbr_err_irq;
    end
  end

  // jumper values shown while reset is held
  assign cpu_irq = reset_n ? irq_r : clock_ratio_jumpers;
  assign sys_mch_chk_irq = mchk_r;
  assign pwr_fail_irq = 1'b0;
  assign mch_hlt_irq = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_IRQ1_FOLLOWS: assert property (
    @(posedge clk) disable iff (!reset_n)
    io_pending |=> cpu_irq[BIA_IRQ_IO])
    else $error("line 1 missed an unmasked request");
  AST_IRQ1_QUIET: assert property (
    @(posedge clk) disable iff (!reset_n)
    !io_pending |=> !cpu_irq[BIA_IRQ_IO])
    else $error("line 1 high with no unmasked request");
  AST_MASK_BLOCKS: assert property (
    @(posedge clk) disable iff (!reset_n)
    (stat_all == 17'h00010 && mask_all[BIA_BRIDGE_BIT])
      |=> !cpu_irq[BIA_IRQ_IO])
    else $error("masked bridge request reached line 1");
  AST_MASK_PASSES: assert property (
    @(posedge clk) disable iff (!reset_n)
    (stat_all[BIA_BRIDGE_BIT] && !mask_all[BIA_BRIDGE_BIT])
      |=> cpu_irq[BIA_IRQ_IO])
    else $error("unmasked bridge request missed line 1");
  AST_WRITE_ONE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (io_wr && sel_one) |=> (mask_one == $past(wr_data)))
    else $error("mask one write lost");
  AST_WRITE_TWO: assert property (
    @(posedge clk) disable iff (!reset_n)
    (io_wr && sel_two) |=> (mask_two == $past(wr_data)))
    else $error("mask two write lost");
  AST_WRITE_THREE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (io_wr && sel_three) |=> (mask_three == $past(wr_data[0])))
    else $error("mask three write lost");
  AST_MASK_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(io_wr && any_sel) |=> $stable(mask_all))
    else $error("mask changed without a write");
  AST_READ_ONE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (io_rd && sel_one) |=> (rd_oe_r && rd_data == $past(stat_one)))
    else $error("port one read wrong");
  AST_READ_TWO: assert property (
    @(posedge clk) disable iff (!reset_n)
    (io_rd && sel_two) |=> (rd_data == $past(stat_two)))
    else $error("port two read wrong");
  AST_READ_THREE: assert property (
    @(posedge clk) disable iff (!reset_n)
    (io_rd && sel_three)
      |=> (rd_data == {7'h00, $past(slot_d_line[3])}))
    else $error("port three read wrong");
  AST_READ_ANSWER: assert property (
    @(posedge clk) disable iff (!reset_n)
    (io_rd && any_sel) |=> rd_data_oe)
    else $error("mapped read not answered");
  AST_NO_RESPONSE: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(io_rd && any_sel) |=> !rd_data_oe)
    else $error("answered an unmapped address");
  AST_IDLE_ZERO: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(io_rd && any_sel) |=> (rd_data == BIA_ZERO8))
    else $error("read data not cleared");
  AST_MCHK: assert property (
    @(posedge clk) disable iff (!reset_n)
    (bridge_missing_mem || bridge_error || sysbr_err_irq)
      |=> sys_mch_chk_irq)
    else $error("machine check missed");
  AST_MCHK_QUIET: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(bridge_missing_mem || bridge_error || sysbr_err_irq)
      |=> !sys_mch_chk_irq)
    else $error("machine check with no cause");
  AST_CAL: assert property (
    @(posedge clk) disable iff (!reset_n)
    calendar_clock_event |=> cpu_irq[BIA_IRQ_CAL])
    else $error("calendar event missed");
  AST_CAL_QUIET: assert property (
    @(posedge clk) disable iff (!reset_n)
    !calendar_clock_event |=> !cpu_irq[BIA_IRQ_CAL])
    else $error("line 2 high with no calendar event");
  AST_CORR: assert property (
    @(posedge clk) disable iff (!reset_n)
    sysbr_corr_irq |=> cpu_irq[BIA_IRQ_CORR])
    else $error("corrected error missed");
  AST_CORR_QUIET: assert property (
    @(posedge clk) disable iff (!reset_n)
    !sysbr_corr_irq |=> !cpu_irq[BIA_IRQ_CORR])
    else $error("line 0 high with no corrected error");
  AST_RSVD: assert property (
    @(posedge clk) disable iff (!reset_n)
    !cpu_irq[BIA_IRQ_RSVD] && !pwr_fail_irq && !mch_hlt_irq)
    else $error("reserved line driven");
  AST_RESET_JUMPERS: assert property (
    @(posedge clk)
    !reset_n |-> (cpu_irq == clock_ratio_jumpers))
    else $error("jumper values not shown during reset");
  AST_MASK_RESET: assert property (
    @(posedge clk)
    $rose(reset_n) |-> (mask_all == BIA_MASK_RST))
    else $error("masks not all set after reset");
  AST_RELEASE_QUIET: assert property (
    @(posedge clk)
    $rose(reset_n) |-> (cpu_irq == 4'h0 && !sys_mch_chk_irq))
    else $error("cpu lines not quiet after reset");

  COV_UNMASK: cover property (@(posedge clk) disable iff (!reset_n)
    io_wr && sel_one && !wr_data[0] ##1 slot_a_line[0] ##1 cpu_irq[1]);
  COV_READ: cover property (@(posedge clk) disable iff (!reset_n)
    io_rd && sel_two);
  COV_MCHK: cover property (@(posedge clk) disable iff (!reset_n)
    bridge_error ##1 sys_mch_chk_irq);
  COV_MASK_HELD: cover property (@(posedge clk) disable iff (!reset_n)
    stat_all[BIA_BRIDGE_BIT] && mask_all[BIA_BRIDGE_BIT] ##1 !cpu_irq[1]);
  COV_RESET_JUMPERS: cover property (@(posedge clk)
    !reset_n && cpu_irq != 4'h0);
endmodule

// >>> verif/bia_host_model.sv
/*
  host-side model of the 8-bit i/o bus: read and write cycles.
  assumes a free-running clk; drives the bus at its falling edge.
*/
`timescale 1ns/100ps
module bia_host_model (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_data_oe,
  output logic [2:0] system_addr_low,
  output logic [2:0] cs_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] wr_data
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  logic [7:0] mask_copy [4]; // own copy, masks never read back
  initial
  begin
    system_addr_low = 3'h0;
    cs_addr = 3'h0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    wr_data = 8'h00;
    foreach (mask_copy[i])
      mask_copy[i] = 8'hFF;
  end
  task automatic io_write(input logic [2:0] adr, input logic [7:0] d);
    @(negedge clk);
    system_addr_low = adr;
    cs_addr = 3'h1;
    io_wr = 1'b1;
    wr_data = d;
    mask_copy[adr[1:0]] = d;
    @(negedge clk);
    io_wr = 1'b0;
    wr_data = ~d;
    cs_addr = ~cs_addr;
  endtask
  // status by port read; io_rd held for one clock
  task automatic io_read(input logic [2:0] adr, input logic [2:0] cs,
                         output logic [7:0] d, output logic oe);
    @(negedge clk);
    system_addr_low = adr;
    cs_addr = cs;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    cs_addr = ~cs;
    oe = rd_data_oe;
    d = rd_data;
  endtask
endmodule

// >>> verif/test_board_interrupt_aggregator.sv
/*
  self-checking bench for the board interrupt aggregator.
  assumes the host model and the package compiled before it.
*/
`timescale 1ns/100ps
module test_board_interrupt_aggregator;
  import bia_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  localparam logic [29:0] BAD_SEL = {6'h39, 6'h22, 6'h19, 6'h20, 6'h2F};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [16:0] src = 17'h00000;
  logic [4:0] sys = 5'h00;
  logic [3:0] jumpers = 4'h0;
  logic [2:0] adr, cs;
  logic io_rd, io_wr, rd_data_oe, pwr, mchk, hlt;
  logic [7:0] wr_data, rd_data;
  logic [3:0] cpu_irq;
  int err_total = 0;
  int comparisons = 0;
  bia_host_model host (.clk(clk), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .system_addr_low(adr), .cs_addr(cs),
    .io_rd(io_rd), .io_wr(io_wr), .wr_data(wr_data));
  bia_board_interrupt_aggregator dut (.clk(clk), .reset_n(reset_n),
    .system_addr_low(adr), .cs_addr(cs), .io_rd(io_rd), .io_wr(io_wr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .slot_a_line(src[3:0]), .slot_b_line({src[8], src[7:5]}),
    .slot_c_line(src[12:9]), .slot_d_line({src[16], src[15:13]}),
    .bridge_irq(src[4]), .calendar_clock_event(sys[1]),
    .sysbr_corr_irq(sys[0]), .sysbr_err_irq(sys[4]),
    .bridge_missing_mem(sys[2]), .bridge_error(sys[3]),
    .clock_ratio_jumpers(jumpers), .cpu_irq(cpu_irq),
    .pwr_fail_irq(pwr), .sys_mch_chk_irq(mchk), .mch_hlt_irq(hlt));
  initial
  begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic line1_exp(input logic [16:0] s);
    return |(s & ~{host.mask_copy[2][0], host.mask_copy[1],
                   host.mask_copy[0]});
  endfunction
  task automatic test_done;
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic read_ports(input logic [16:0] exp);
    logic [7:0] d;
    logic oe;
    host.io_read(3'h4, 3'h1, d, oe);
    check(d, exp[7:0]);
    check({7'h00, oe}, 8'h01);
    host.io_read(3'h5, 3'h1, d, oe);
    check(d, exp[15:8]);
    check({7'h00, oe}, 8'h01);
    host.io_read(3'h6, 3'h1, d, oe);
    check(d, {7'h00, exp[16]});
    check({7'h00, oe}, 8'h01);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    reset_n = 1'b0;
    src = 17'h1FFFF;
    sys = 5'h00;
    jumpers = 4'hA;
    @(negedge clk);
    check({4'h0, cpu_irq}, 8'h0A);
    jumpers = 4'h5;
    @(negedge clk);
    check({4'h0, cpu_irq}, 8'h05);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    check({4'h0, cpu_irq}, 8'h00);
    check({5'h00, pwr, hlt, mchk}, 8'h00);
    read_ports(17'h1FFFF);
  endtask
  task automatic test_masked;
    @(negedge clk);
    src = 17'h00010;
    @(negedge clk);
    check({7'h00, cpu_irq[1]}, {7'h00, line1_exp(src)});
    read_ports(17'h00010);
    host.io_write(3'h4, 8'hEF);
    @(negedge clk);
    check({7'h00, cpu_irq[1]}, {7'h00, line1_exp(src)});
    host.io_write(3'h4, 8'hFF);
    @(negedge clk);
    check({7'h00, cpu_irq[1]}, 8'h00);
  endtask
  task automatic test_decode;
    logic [7:0] d;
    logic oe;
    for (int i = 0; i < 5; i++)
    begin
      host.io_read(BAD_SEL[6*i+3 +: 3], BAD_SEL[6*i +: 3], d, oe);
      check({7'h00, oe}, 8'h00);
      check(d, 8'h00);
    end
  endtask
  task automatic test_mask_map;
    logic [16:0] one;
    for (int k = 0; k < BIA_NSRC; k++)
    begin
      one = 17'h00001 << k;
      host.io_write(3'h4, ~one[7:0]);
      host.io_write(3'h5, ~one[15:8]);
      host.io_write(3'h6, {7'h7F, ~one[16]});
      src = one;
      read_ports(one);
      check({7'h00, cpu_irq[1]}, 8'h01);
      src = ~one;
      read_ports(~one);
      check({7'h00, cpu_irq[1]}, 8'h00);
    end
  endtask
  task automatic test_system_lines;
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk);
      src = 17'h00000;
      sys = 5'h01 << i;
      @(negedge clk);
      check({2'h0, pwr, hlt, cpu_irq[3], mchk, cpu_irq[2], cpu_irq[0]},
            {5'h00, |sys[4:2], sys[1], sys[0]});
    end
  endtask
  // ----------------------------------------------------------------
  // run and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    test_reset();
    test_masked();
    test_decode();
    test_mask_map();
    test_system_lines();
    test_reset();
    test_done();
  end
  initial
  begin
    #200000;
    err_total++;
    test_done();
  end
endmodule
